// ### ceeu_far_model.sv
`timescale 1ns/1ps
module ceeu_far_model (
   input wire logic i_clock,
   input wire logic i_rst,
   input wire logic [2:0] i_req,
   output logic o_coupler_addr_err,
   output logic o_ms_addr_parity_err,
   output logic o_double_err,
   output logic o_mem_parity_err,
   output logic o_secded_mode
);
   logic [2:0] flag_q;
   logic [2:0] flag_d;
   logic secded_q;
   logic secded_d;
   always_comb
   begin
      flag_d = i_req;
      // Each bit-53 report flips between correcting and parity mode
      secded_d = secded_q ^ flag_q[2];
   end
   always_ff @(posedge i_clock or posedge i_rst)
      if (i_rst)
      begin
         flag_q <= 3'h0;
         secded_q <= 1'b1;
      end
      else
      begin
         flag_q <= flag_d;
         secded_q <= secded_d;
      end
   assign o_coupler_addr_err = flag_q[0];
   assign o_ms_addr_parity_err = flag_q[1];
   assign o_double_err = flag_q[2] & secded_q;
   assign o_mem_parity_err = flag_q[2] & !secded_q;
   assign o_secded_mode = secded_q;
endmodule

// ### ceeu_pkg.sv
package ceeu_pkg;
   // Register byte offsets
   localparam logic [7:0] CONFIG_OFS = 8'h00;
   localparam logic [7:0] STATUS_OFS = 8'h04;
   localparam logic [7:0] MODE_OFS = 8'h08;
   localparam logic [7:0] EXIT_OFS = 8'h0C;
   // Config register fields
   localparam int CFG_XJ_ENABLE_BIT = 0;
   localparam int CFG_MONITOR_FLAG_BIT = 1;
   localparam logic [1:0] CONFIG_RESET = 2'h0;
   // Condition vector index: 0..5 stand for exit bits 48..53
   localparam int NUM_COND = 6;
   localparam int COND_RANGE = 0;
   localparam int COND_INFINITE = 1;
   localparam int COND_INDEFINITE = 2;
   localparam int COND_FLAG_ADDR = 3;
   localparam int COND_MC_PARITY = 4;
   localparam int COND_DATA_ERR = 5;
   // Exit word layout
   localparam int WORD_W = 60;
   localparam int PADDR_W = 18;
   localparam int EXIT_COND_LSB = 48;
   localparam int EXIT_PADDR_LSB = 30;
   // Exchange package mode word
   localparam logic [3:0] XPKG_MODE_WORD = 4'h3;
   localparam int MODE_LO_LSB = 48;
   localparam int MODE_HI_LSB = 57;
   localparam logic [5:0] MODE_RESET = 6'h00;
   // Block copy opcodes
   localparam logic [8:0] OP_BCOPY_READ = 9'h009;
   localparam logic [8:0] OP_BCOPY_WRITE = 9'h00A;
   // Resume parcels
   localparam logic [1:0] PARCEL_FULL = 2'h0;
   localparam logic [1:0] PARCEL_HALF = 2'h2;
   // Response combos
   typedef enum logic [1:0]
   {
      CEEU_RESP_STOP_MON = 2'h0,
      CEEU_RESP_EXCHANGE = 2'h1,
      CEEU_RESP_STOP_OFF = 2'h2
   } ceeu_resp_t;
   typedef enum logic [1:0]
   {
      CEEU_IDLE = 2'b00,
      CEEU_WRITE = 2'b01,
      CEEU_CLEAR_P = 2'b11,
      CEEU_EXCH = 2'b10
   } ceeu_state_t;
endpackage

// ### ceeu_top.sv
// Function
// - Illegal op, breakpoint, fetch or branch range error always exit.
// - Other errors interrupt only when detected and mode bit set.
// - Mode bits come from exchange package word three.
// - Every error exit writes program address into relative word zero.
// - Mode-enabled condition bits also go into relative word zero.
// - Bits 48-50 detected internally, enabled by same-number mode bits.
// - Bits 51, 52 from controller, 53 from coupler, enabled by 57-59.
// - Bit 51 on coupler address transfer error during flag operation.
// - Bit 52 on transfer parity error, kind depends on processor index.
// - Bit 53 on double error in SECDED, data parity error otherwise.
// - Conditions after exchange jump start belong to incoming program.
// - Stored program address is uncorrected, possibly already advanced.
// - Exit word: conditions 53..48, address 47..30, other bits zero.
// - Response chosen by switch setting and monitor flag, three combos.
// - Block copy 011/012 chooses copy or flag operation by bit 23s.
// - Full exit resumes at parcel 0 of next instruction word.
// - Half exit resumes at parcel 2 of current instruction word.
// - Flag register lives in controller, reached only through coupler.
// - Illegal instruction acts as a pass, changing no register.
// - Stopping exit stores word zero, then clears program address.
//
// The AHB-Lite slave port and the register offsets were decided locally.
`timescale 1ns/1ps
module ceeu_top #(
   parameter int CPU_INDEX = 0
)
(
   input wire logic i_clock,
   input wire logic i_rst,
   input wire logic i_hsel,
   input wire logic [31:0] i_haddr,
   input wire logic [1:0] i_htrans,
   input wire logic i_hwrite,
   input wire logic [2:0] i_hsize,
   input wire logic [31:0] i_hwdata,
   input wire logic i_hready,
   output logic [31:0] o_hrdata,
   output logic o_hreadyout,
   output logic o_hresp,
   input wire logic i_xpkg_wr,
   input wire logic [3:0] i_xpkg_addr,
   input wire logic [59:0] i_xpkg_data,
   input wire logic i_xjump_start,
   input wire logic [17:0] i_prog_addr,
   input wire logic i_illegal_instr,
   input wire logic i_breakpoint,
   input wire logic i_range_err_fetch,
   input wire logic i_range_err_data,
   input wire logic i_infinite_op,
   input wire logic i_indefinite_op,
   input wire logic i_coupler_addr_err,
   input wire logic i_mc_data_parity_err,
   input wire logic i_mc_addr_parity_err,
   input wire logic i_ms_addr_parity_err,
   input wire logic i_secded_mode,
   input wire logic i_double_err,
   input wire logic i_mem_parity_err,
   input wire logic i_bcopy_start,
   input wire logic [8:0] i_bcopy_opcode,
   input wire logic i_ext_addr_b23,
   input wire logic i_ext_fl_b23,
   input wire logic i_bcopy_done,
   input wire logic i_full_exit,
   input wire logic i_half_exit,
   input wire logic [17:0] i_word_addr,
   output logic o_pass_instr,
   output logic o_rwz_wr,
   output logic [59:0] o_rwz_data,
   output logic o_p_clear,
   output logic o_proc_stop,
   output logic o_exchange_req,
   output logic o_block_copy_start,
   output logic o_flag_op_start,
   output logic o_flag_op_active,
   output logic o_resume_valid,
   output logic [17:0] o_resume_addr,
   output logic [1:0] o_resume_parcel
);
   localparam int NC = ceeu_pkg::NUM_COND;

   function automatic logic [59:0] exit_word(input logic [5:0] c,
                                             input logic [17:0] p);
      logic [59:0] w;
      w = '0;
      w[ceeu_pkg::EXIT_COND_LSB +: 6] = c;
      w[ceeu_pkg::EXIT_PADDR_LSB +: 18] = p;
      return w;
   endfunction

   // Bus slave state
   logic wr_pend_q, wr_pend_d;
   logic [7:0] addr_q, addr_d;
   logic [1:0] config_q, config_d;
   logic [NC-1:0] status_q, status_d;
   logic [NC-1:0] mode_q, mode_d;
   logic [23:0] exit_log_q, exit_log_d;
   logic [31:0] rdata_q, rdata_d;
   // Exit sequencer state
   ceeu_pkg::ceeu_state_t state_q, state_d;
   logic [5:0] ex_cond_q, ex_cond_d;
   logic [17:0] ex_paddr_q, ex_paddr_d;
   logic stop_kind_q, stop_kind_d;
   logic flag_op_q, flag_op_d;
   logic resume_valid_q, resume_valid_d;
   logic [17:0] resume_addr_q, resume_addr_d;
   logic [1:0] resume_parcel_q, resume_parcel_d;
   logic [59:0] rwz_data_q, rwz_data_d;

   logic addr_phase;
   logic [NC-1:0] cond_now;
   logic uncond;
   logic [NC-1:0] exit_bits;
   logic take_exit;
   ceeu_pkg::ceeu_resp_t resp;
   logic is_bcopy;

   assign addr_phase = i_hsel && i_htrans[1] && i_hready;
   assign o_hreadyout = 1'b1;
   assign o_hresp = 1'b0;
   assign o_hrdata = rdata_q;

   // Detected conditions, index 0..5 for exit bits 48..53
   always_comb
   begin
      cond_now = '0;
      cond_now[ceeu_pkg::COND_RANGE] = i_range_err_data
                                       | i_range_err_fetch;
      cond_now[ceeu_pkg::COND_INFINITE] = i_infinite_op;
      cond_now[ceeu_pkg::COND_INDEFINITE] = i_indefinite_op;
      cond_now[ceeu_pkg::COND_FLAG_ADDR] = i_coupler_addr_err
                                           & flag_op_q;
      if (CPU_INDEX != 0)
      begin
         cond_now[ceeu_pkg::COND_MC_PARITY] = i_mc_data_parity_err
            | i_mc_addr_parity_err;
      end
      else
      begin
         cond_now[ceeu_pkg::COND_MC_PARITY] = i_ms_addr_parity_err;
      end
      cond_now[ceeu_pkg::COND_DATA_ERR] = i_secded_mode ? i_double_err
                                          : i_mem_parity_err;
   end

   assign uncond = i_illegal_instr | i_breakpoint | i_range_err_fetch;
   assign exit_bits = cond_now & mode_q;
   assign take_exit = (uncond || (exit_bits != '0))
                      && (state_q == ceeu_pkg::CEEU_IDLE);
   assign o_pass_instr = i_illegal_instr;

   always_comb
   begin
      if (!config_q[ceeu_pkg::CFG_XJ_ENABLE_BIT])
      begin
         resp = ceeu_pkg::CEEU_RESP_STOP_OFF;
      end
      else if (config_q[ceeu_pkg::CFG_MONITOR_FLAG_BIT])
      begin
         resp = ceeu_pkg::CEEU_RESP_STOP_MON;
      end
      else
      begin
         resp = ceeu_pkg::CEEU_RESP_EXCHANGE;
      end
   end

   assign is_bcopy = i_bcopy_start
                     && (i_bcopy_opcode == ceeu_pkg::OP_BCOPY_READ
                     || i_bcopy_opcode == ceeu_pkg::OP_BCOPY_WRITE);

   // Exit sequencer and block copy next state
   always_comb
   begin
      state_d = state_q;
      ex_cond_d = ex_cond_q;
      ex_paddr_d = ex_paddr_q;
      stop_kind_d = stop_kind_q;
      flag_op_d = flag_op_q;
      resume_valid_d = 1'b0;
      resume_addr_d = resume_addr_q;
      resume_parcel_d = resume_parcel_q;
      rwz_data_d = rwz_data_q;
      o_rwz_wr = 1'b0;
      o_p_clear = 1'b0;
      o_proc_stop = 1'b0;
      o_exchange_req = 1'b0;
      o_block_copy_start = 1'b0;
      o_flag_op_start = 1'b0;
      case (state_q)
         ceeu_pkg::CEEU_IDLE:
         begin
            if (take_exit)
            begin
               ex_cond_d = exit_bits;
               if (i_range_err_fetch)
               begin
                  ex_cond_d[ceeu_pkg::COND_RANGE] = 1'b1;
               end
               ex_paddr_d = i_prog_addr;
               stop_kind_d = (resp != ceeu_pkg::CEEU_RESP_EXCHANGE);
               state_d = ceeu_pkg::CEEU_WRITE;
            end
         end
         ceeu_pkg::CEEU_WRITE:
         begin
            o_rwz_wr = 1'b1;
            rwz_data_d = exit_word(ex_cond_q, ex_paddr_q);
            state_d = stop_kind_q ? ceeu_pkg::CEEU_CLEAR_P
                      : ceeu_pkg::CEEU_EXCH;
         end
         ceeu_pkg::CEEU_CLEAR_P:
         begin
            o_p_clear = 1'b1;
            o_proc_stop = 1'b1;
            state_d = ceeu_pkg::CEEU_IDLE;
         end
         ceeu_pkg::CEEU_EXCH:
         begin
            o_exchange_req = 1'b1;
            state_d = ceeu_pkg::CEEU_IDLE;
         end
         default:
         begin
            state_d = ceeu_pkg::CEEU_IDLE;
         end
      endcase
      if (is_bcopy && !flag_op_q)
      begin
         if (i_ext_addr_b23 && i_ext_fl_b23)
         begin
            o_flag_op_start = 1'b1;
            flag_op_d = 1'b1;
         end
         else
         begin
            o_block_copy_start = 1'b1;
         end
      end
      else if (i_bcopy_done)
      begin
         flag_op_d = 1'b0;
      end
      if (i_full_exit)
      begin
         resume_valid_d = 1'b1;
         resume_addr_d = i_word_addr + 18'h00001;
         resume_parcel_d = ceeu_pkg::PARCEL_FULL;
      end
      else if (i_half_exit)
      begin
         resume_valid_d = 1'b1;
         resume_addr_d = i_word_addr;
         resume_parcel_d = ceeu_pkg::PARCEL_HALF;
      end
   end

   // Register file next state
   always_comb
   begin
      wr_pend_d = addr_phase && i_hwrite;
      addr_d = addr_phase ? i_haddr[7:0] : addr_q;
      config_d = config_q;
      status_d = status_q;
      mode_d = mode_q;
      exit_log_d = exit_log_q;
      rdata_d = rdata_q;
      if (wr_pend_q)
      begin
         case (addr_q)
            ceeu_pkg::CONFIG_OFS: config_d = i_hwdata[1:0];
            ceeu_pkg::STATUS_OFS: status_d = status_q & ~i_hwdata[NC-1:0];
            ceeu_pkg::MODE_OFS: mode_d = i_hwdata[NC-1:0];
            default: config_d = config_q;
         endcase
      end
      if (i_xjump_start)
      begin
         status_d = '0;
      end
      if (i_xpkg_wr && i_xpkg_addr == ceeu_pkg::XPKG_MODE_WORD)
      begin
         mode_d = {i_xpkg_data[ceeu_pkg::MODE_HI_LSB +: 3],
                   i_xpkg_data[ceeu_pkg::MODE_LO_LSB +: 3]};
      end
      status_d = status_d | cond_now;
      if (state_q == ceeu_pkg::CEEU_WRITE)
      begin
         exit_log_d = {ex_cond_q, ex_paddr_q};
      end
      if (addr_phase && !i_hwrite)
      begin
         case (i_haddr[7:0])
            ceeu_pkg::CONFIG_OFS: rdata_d = {30'h0, config_q};
            ceeu_pkg::STATUS_OFS: rdata_d = {26'h0, status_q};
            ceeu_pkg::MODE_OFS: rdata_d = {26'h0, mode_q};
            ceeu_pkg::EXIT_OFS: rdata_d = {8'h00, exit_log_q};
            default: rdata_d = 32'h0000_0000;
         endcase
      end
   end

   always_ff @(posedge i_clock or posedge i_rst)
   begin
      if (i_rst)
      begin
         state_q <= ceeu_pkg::CEEU_IDLE;
         ex_cond_q <= '0;
         ex_paddr_q <= '0;
         stop_kind_q <= 1'b0;
         flag_op_q <= 1'b0;
         resume_valid_q <= 1'b0;
         resume_addr_q <= '0;
         resume_parcel_q <= 2'h0;
         rwz_data_q <= '0;
         wr_pend_q <= 1'b0;
         addr_q <= 8'h00;
         config_q <= ceeu_pkg::CONFIG_RESET;
         status_q <= '0;
         mode_q <= ceeu_pkg::MODE_RESET;
         exit_log_q <= '0;
         rdata_q <= 32'h0000_0000;
      end
      else
      begin
         state_q <= state_d;
         ex_cond_q <= ex_cond_d;
         ex_paddr_q <= ex_paddr_d;
         stop_kind_q <= stop_kind_d;
         flag_op_q <= flag_op_d;
         resume_valid_q <= resume_valid_d;
         resume_addr_q <= resume_addr_d;
         resume_parcel_q <= resume_parcel_d;
         rwz_data_q <= rwz_data_d;
         wr_pend_q <= wr_pend_d;
         addr_q <= addr_d;
         config_q <= config_d;
         status_q <= status_d;
         mode_q <= mode_d;
         exit_log_q <= exit_log_d;
         rdata_q <= rdata_d;
      end
   end

   assign o_rwz_data = rwz_data_q;
   assign o_flag_op_active = flag_op_q;
   assign o_resume_valid = resume_valid_q;
   assign o_resume_addr = resume_addr_q;
   assign o_resume_parcel = resume_parcel_q;
endmodule

// ### ceeu_top_asserts.sv
`timescale 1ns/1ps
module ceeu_top_chk (
   input wire logic i_clock,
   input wire logic i_rst,
   input wire logic i_illegal_instr,
   input wire logic i_breakpoint,
   input wire logic i_range_err_fetch,
   input wire logic [17:0] i_prog_addr,
   input wire logic i_bcopy_start,
   input wire logic [8:0] i_bcopy_opcode,
   input wire logic i_ext_addr_b23,
   input wire logic i_ext_fl_b23,
   input wire logic i_full_exit,
   input wire logic i_half_exit,
   input wire logic [17:0] i_word_addr,
   input wire logic o_pass_instr,
   input wire logic o_rwz_wr,
   input wire logic [59:0] o_rwz_data,
   input wire logic o_p_clear,
   input wire logic o_proc_stop,
   input wire logic o_exchange_req,
   input wire logic o_block_copy_start,
   input wire logic o_flag_op_start,
   input wire logic o_flag_op_active,
   input wire logic o_resume_valid,
   input wire logic [17:0] o_resume_addr,
   input wire logic [1:0] o_resume_parcel
);
   logic idle;
   logic both;
   logic op_ok;
   assign idle = !o_rwz_wr && !o_p_clear && !o_exchange_req;
   assign both = i_ext_addr_b23 && i_ext_fl_b23;
   assign op_ok = i_bcopy_opcode == ceeu_pkg::OP_BCOPY_READ
      || i_bcopy_opcode == ceeu_pkg::OP_BCOPY_WRITE;
   default clocking @(posedge i_clock);
   endclocking
   default disable iff (i_rst);
   uncond_exit_a: assert property (
      idle && (i_illegal_instr || i_breakpoint || i_range_err_fetch)
      |=> o_rwz_wr) else $error("missed exit");
   word_format_a: assert property (
      o_rwz_wr |=> o_rwz_data[59:54] == 6'h00 && o_rwz_data[29:0] == 30'h0
      && o_rwz_data[47:30] == $past(i_prog_addr, 2)) else $error("bad word");
   resp_kind_a: assert property (
      o_rwz_wr |=> o_p_clear == o_proc_stop && (o_p_clear ^ o_exchange_req))
      else $error("bad response");
   clear_after_a: assert property (
      o_p_clear |-> $past(o_rwz_wr) && !o_rwz_wr) else $error("early clear");
   copy_select_a: assert property (
      i_bcopy_start && !o_flag_op_active && op_ok |-> o_flag_op_start == both
      && o_block_copy_start == !both) else $error("bad select");
   flag_active_a: assert property (
      o_flag_op_start |=> o_flag_op_active) else $error("no flag op");
   full_resume_a: assert property (
      i_full_exit |=> o_resume_valid
      && o_resume_parcel == ceeu_pkg::PARCEL_FULL
      && o_resume_addr == $past(i_word_addr) + 18'h1) else $error("bad full");
   half_resume_a: assert property (
      i_half_exit && !i_full_exit |=> o_resume_valid && o_resume_addr ==
      $past(i_word_addr) && o_resume_parcel == ceeu_pkg::PARCEL_HALF)
      else $error("bad half");
   pass_instr_a: assert property (
      i_illegal_instr |-> o_pass_instr) else $error("no pass");
endmodule

// ### ceeu_top_tb.sv
`timescale 1ns/1ps
`define chk(a,b) begin total_checks++; if ((a) !== (b)) begin errors++; \
 $display("[ERR] %0t got %h exp %h", $time, a, b); end end
module ceeu_top_tb;
   logic i_clock = 0, i_rst = 1, i_hsel = 0, i_hwrite = 0, i_hready;
   logic [31:0] i_haddr = 0, i_hwdata = 0, o_hrdata, r;
   logic [1:0] i_htrans = 0, o_resume_parcel;
   logic [2:0] i_hsize = 0;
   logic i_xpkg_wr = 0, i_xjump_start = 0, i_bcopy_start = 0, i_bcopy_done = 0;
   logic i_full_exit = 0, i_half_exit = 0;
   logic i_ext_addr_b23 = 0, i_ext_fl_b23 = 0;
   logic [3:0] i_xpkg_addr = 0;
   logic [59:0] i_xpkg_data = 0, o_rwz_data;
   logic [17:0] i_prog_addr = 0, i_word_addr = 0, o_resume_addr;
   logic [8:0] i_bcopy_opcode = 0, evt = 0;
   logic i_mc_data_parity_err = 0, i_mc_addr_parity_err = 0;
   logic i_illegal_instr, i_breakpoint, i_range_err_fetch, i_range_err_data;
   logic i_infinite_op, i_indefinite_op, i_coupler_addr_err, i_secded_mode;
   logic i_ms_addr_parity_err, i_double_err, i_mem_parity_err, o_pass_instr;
   logic o_hreadyout, o_hresp, o_rwz_wr, o_p_clear, o_proc_stop, o_exchange_req;
   logic o_block_copy_start, o_flag_op_start, o_flag_op_active, o_resume_valid;
   logic [31:0] seed = 32'h7B4FD87C;
   logic [60:0] notes[$], note;
   int errors = 0, total_checks = 0;
   assign i_hready = o_hreadyout;
   assign {i_indefinite_op, i_infinite_op, i_range_err_data} = evt[5:3];
   assign {i_range_err_fetch, i_breakpoint, i_illegal_instr} = evt[2:0];
   always #10 i_clock = ~i_clock;
   ceeu_top u_ceeu_top (.*);
   ceeu_far_model u_ceeu_far_model (
      .i_clock(i_clock),
      .i_rst(i_rst),
      .i_req(evt[8:6]),
      .o_coupler_addr_err(i_coupler_addr_err),
      .o_ms_addr_parity_err(i_ms_addr_parity_err),
      .o_double_err(i_double_err),
      .o_mem_parity_err(i_mem_parity_err),
      .o_secded_mode(i_secded_mode)
   );
   function automatic logic [31:0] xs();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction
   task tally_and_finish();
      $display("checks %0d errors %0d", total_checks, errors);
      if (errors == 0 && total_checks > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask
   task bus(input logic w, input logic [7:0] a, input logic [31:0] d, e);
      i_hsel <= 1;
      i_haddr <= {24'h0, a};
      i_htrans <= 2'h2;
      i_hwrite <= w;
      i_hsize <= 3'h2;
      do @(posedge i_clock); while (o_hreadyout !== 1'b1);
      i_htrans <= 2'h0;
      i_hsel <= 0;
      i_hwdata <= d;
      do @(posedge i_clock); while (o_hreadyout !== 1'b1);
      if (!w) `chk(o_hrdata, e)
      `chk(o_hresp, 1'b0)
   endtask
   // One event source for n cycles; note the exit word if one is due
   task fire(input int k, input int n, input logic nt, input logic st);
      logic [5:0] c;
      c = (k == 2) ? 6'h01 : (k > 2) ? 6'h01 << (k - 3) : 6'h00;
      r = xs();
      i_prog_addr <= r[17:0];
      if (nt) notes.push_back({st, 6'h00, c, r[17:0], 30'h0});
      evt[k] <= 1'b1;
      repeat (n) @(posedge i_clock);
      evt <= 9'h000;
      repeat (6) @(posedge i_clock);
   endtask
   task bcopy(input logic a, input logic f);
      i_bcopy_opcode <= a ? ceeu_pkg::OP_BCOPY_READ : ceeu_pkg::OP_BCOPY_WRITE;
      i_ext_addr_b23 <= a;
      i_ext_fl_b23 <= f;
      i_bcopy_start <= 1;
      @(negedge i_clock);
      `chk(o_flag_op_start, a & f)
      `chk(o_block_copy_start, !(a & f))
      @(posedge i_clock);
      i_bcopy_start <= 0;
      @(negedge i_clock);
      `chk(o_flag_op_active, a & f)
      @(posedge i_clock);
   endtask
   task endcopy();
      i_bcopy_done <= 1;
      @(posedge i_clock);
      i_bcopy_done <= 0;
      @(negedge i_clock);
      `chk(o_flag_op_active, 1'b0)
      @(posedge i_clock);
   endtask
   always @(negedge i_clock)
      if (o_rwz_wr === 1'b1)
      begin
         @(negedge i_clock);
         if (notes.size() == 0)
         begin
            errors++;
            $display("[ERR] %0t unexpected exit", $time);
         end
         else
         begin
            note = notes.pop_front();
            `chk(o_rwz_data, note[59:0])
            `chk(o_proc_stop, note[60])
            `chk(o_exchange_req, !note[60])
            `chk(o_p_clear, note[60])
         end
      end
   initial
   begin
      repeat (10) @(posedge i_clock);
      i_rst <= 0;
      @(posedge i_clock);
      bus(0, ceeu_pkg::CONFIG_OFS, 32'h0, 32'h0);
      bus(0, ceeu_pkg::MODE_OFS, 32'h0, 32'h0);
      bus(0, 8'h10, 32'h0, 32'h0);
      fire(4, 1, 0, 0);
      bus(0, ceeu_pkg::STATUS_OFS, 32'h0, 32'h2);
      bus(1, ceeu_pkg::STATUS_OFS, 32'h3F, 32'h0);
      bus(0, ceeu_pkg::STATUS_OFS, 32'h0, 32'h0);
      $display("masked test done");
      r = xs();
      i_xpkg_addr <= ceeu_pkg::XPKG_MODE_WORD;
      i_xpkg_data <= {3'h7, 6'h00, 3'h7, r, r[15:0]};
      i_xpkg_wr <= 1;
      @(posedge i_clock);
      i_xpkg_wr <= 0;
      bus(0, ceeu_pkg::MODE_OFS, 32'h0, 32'h3F);
      for (int k = 0; k < 9; k++)
      begin
         bus(1, ceeu_pkg::CONFIG_OFS, k % 4, 32'h0);
         if (k == 6) bcopy(1, 1);
         fire(k, 1, 1, k % 4 != 1);
         if (k == 6) endcopy();
      end
      fire(8, 1, 1, 1);
      bus(0, ceeu_pkg::STATUS_OFS, 32'h0, 32'h3F);
      fire(0, 2, 1, 1);
      i_xjump_start <= 1;
      @(posedge i_clock);
      i_xjump_start <= 0;
      bus(0, ceeu_pkg::STATUS_OFS, 32'h0, 32'h0);
      $display("exit test done");
      for (int i = 0; i < 4; i++)
      begin
         bcopy(i[1], i[0]);
         endcopy();
      end
      for (int i = 0; i < 2; i++)
      begin
         r = xs();
         i_word_addr <= r[17:0];
         i_full_exit <= (i == 0);
         i_half_exit <= (i == 1);
         @(posedge i_clock);
         i_full_exit <= 0;
         i_half_exit <= 0;
         @(negedge i_clock);
         `chk(o_resume_addr, i == 0 ? r[17:0] + 18'h1 : r[17:0])
         `chk(o_resume_parcel, i == 0 ? 2'h0 : 2'h2)
         `chk(o_resume_valid, 1'b1)
         @(posedge i_clock);
      end
      $display("copy test done");
      `chk(notes.size(), 0)
      tally_and_finish();
   end
   initial
   begin
      repeat (3000) @(posedge i_clock);
      errors++;
      $display("[ERR] %0t watchdog", $time);
      tally_and_finish();
   end
endmodule
bind ceeu_top ceeu_top_chk u_ceeu_top_chk (.*);
